// ===== rtl/pi_pkg.sv
// Purpose: shared constants and types for the pi loop controller
// Assumes: 125 MHz system clock, values in the relay's internal units
// Notes: gain in hundredths, integral time in whole seconds
package pi_pkg;
  // clock and sampling
  localparam int CLK_KHZ = 125000;
  localparam int SAMPLE_MS = 500;
  localparam int SAMPLE_CYCLES = SAMPLE_MS * CLK_KHZ;
  // integral divisor factor: 100 (gain hundredths) * 1000 ms / ts ms
  localparam int TS_DEN = 100 * 1000 / SAMPLE_MS;
  // value ranges
  localparam int OUT_MAX = 1000;
  localparam int LIM_MIN = -10000;
  localparam int LIM_MAX = 20000;
  localparam int GAIN_MAX = 9999;
  localparam int SCALE_MAX = 1000;
  localparam int SHIFT_MAX = 10000;
  localparam int MIN_MAX = 99;
  localparam int SEC_MAX = 59;
  localparam int SEC_PER_MIN = 60;
  localparam int HUNDRED = 100;
  // fixed point fraction bits of the integral sum
  localparam int FRAC = 16;
  localparam int ACC_FULL = OUT_MAX * (2 ** FRAC);
  // divider widths
  localparam int DIV_NW = 48;
  localparam int DIV_DW = 21;

  // controller state, one-hot
  typedef enum logic [3:0] {
    ST_MANUAL = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_DIV = 4'b0100,
    ST_APPLY = 4'b1000
  } ctrl_state_t;

  // tuning set taken at the start of automatic operation
  typedef struct packed {
    logic [13:0] gain;
    logic [12:0] ti_s;
    logic dir_down;
  } tuning_t;

  // application presets, selector 0 means user values
  function automatic tuning_t preset_tuning(input logic [2:0] sel);
    tuning_t t;
    t = '{gain: 14'h0000, ti_s: 13'h0001, dir_down: 1'b0};
    case (sel)
      3'h1: t = '{gain: 14'h0032, ti_s: 13'h001e, dir_down: 1'b0};
      3'h2: t = '{gain: 14'h0064, ti_s: 13'h0078, dir_down: 1'b0};
      3'h3: t = '{gain: 14'h012c, ti_s: 13'h0005, dir_down: 1'b0};
      3'h4: t = '{gain: 14'h0078, ti_s: 13'h000c, dir_down: 1'b0};
      3'h5: t = '{gain: 14'h0064, ti_s: 13'h0001, dir_down: 1'b0};
      3'h6: t = '{gain: 14'h0046, ti_s: 13'h0014, dir_down: 1'b0};
      default: t = '{gain: 14'h0000, ti_s: 13'h0001, dir_down: 1'b0};
    endcase
    return t;
  endfunction

  // signed saturation to [lo, hi]
  function automatic logic signed [48:0] sat(input logic signed [48:0] v,
                                            input int lo, input int hi);
    logic signed [48:0] r;
    r = v;
    if (v > 49'(signed'(hi))) r = 49'(signed'(hi));
    if (v < 49'(signed'(lo))) r = 49'(signed'(lo));
    return r;
  endfunction
endpackage

// ===== rtl/divide_seq.sv
// Purpose: unsigned restoring divider, one quotient bit per clock
// Assumes: den is never zero while a division runs
// Notes: start while busy is ignored; done pulses once per division
`timescale 1ns/1ns
module divide_seq #(
  parameter int NW = 48,
  parameter int DW = 21
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic done,
  output logic [NW-1:0] quo
);
  localparam int CW = $clog2(NW + 1);
  logic [DW-1:0] rem_r, rem_nxt; // partial remainder
  logic [NW-1:0] q_r, q_nxt; // dividend shifting into quotient
  logic [DW-1:0] d_r, d_nxt; // held divisor
  logic [CW-1:0] cnt_r, cnt_nxt; // bits still to produce
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [DW:0] shifted; // remainder with next dividend bit

  if (NW < 2 || DW < 2) begin : g_chk
    $error("divider widths too small");
  end

  ////////////////////////////////////////////////////////////////////
  // next state: load on start, then shift and subtract
  always_comb begin
    rem_nxt = rem_r;
    q_nxt = q_r;
    d_nxt = d_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    shifted = {rem_r, q_r[NW-1]};
    if (busy_r) begin
      // compare trial remainder against divisor
      if (shifted >= {1'b0, d_r}) begin
        rem_nxt = DW'(shifted - {1'b0, d_r});
        q_nxt = {q_r[NW-2:0], 1'b1};
      end else begin
        rem_nxt = shifted[DW-1:0];
        q_nxt = {q_r[NW-2:0], 1'b0};
      end
      cnt_nxt = CW'(cnt_r - 1'b1);
      // last bit done
      if (cnt_r == CW'(1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end else if (start) begin
      rem_nxt = '0;
      q_nxt = num;
      d_nxt = den;
      cnt_nxt = CW'(NW);
      busy_nxt = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rem_r <= '0;
      q_r <= '0;
      d_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      rem_r <= rem_nxt;
      q_r <= q_nxt;
      d_r <= d_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
  assign quo = q_r;
endmodule

// ===== rtl/pi_loop_controller.sv
// Purpose: proportional-integral loop controller with manual mode
// Assumes: all inputs synchronous to sys_clk, settings held static
// Notes: output updates once per sample in automatic mode
// Operation
// RL1 - auto_manual_select high is automatic, low manual
// RL2 - manual mode outputs manual value, no regulation
// RL3 - automatic start loads integral sum from manual
// RL4 - scaled reading is reading times gain plus shift
// RL5 - zero error keeps output unchanged
// RL6 - upwards: high reading lowers, low reading raises
// RL7 - downwards: high reading raises, low reading lowers
// RL8 - scaled reading clamped between floor and ceiling
// RL9 - hold_clear forces zero, overrides mode input
// RL10 - manual value limited to 0 through 1000
// RL11 - output always saturated to 0 through 1000
// RL12 - floor and ceiling limited to -10000..20000
// RL13 - setpoint limited to -10000..20000
// RL14 - gain held as hundredths, 0 to 99.99
// RL15 - integral time minutes and seconds, 1s..99:59
// RL16 - direction frozen while automatic operation runs
// RL17 - decimal places only for display, not arithmetic
// RL18 - presets load gain, time and direction together
// RL19 - one calculation every 500 ms sample
// RL20 - error is setpoint minus scaled reading
// RL21 - proportional part is gain times current error
// RL22 - integral adds gain times ts/ti times error
// RL23 - output is sum, error inverted when downwards
// RL24 - integral sum limited to output range
`timescale 1ns/1ns
module pi_loop_controller
  import pi_pkg::*;
#(
  parameter int SAMPLE_CYCLES = pi_pkg::SAMPLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic auto_manual_select,
  input wire logic hold_clear,
  input wire logic signed [15:0] process_reading,
  input wire logic signed [15:0] scale_factor,
  input wire logic signed [15:0] zero_shift,
  input wire logic signed [15:0] reading_floor,
  input wire logic signed [15:0] reading_ceiling,
  input wire logic signed [15:0] target_setpoint,
  input wire logic [10:0] manual_output_value,
  input wire logic [13:0] proportional_gain,
  input wire logic [6:0] integral_minutes,
  input wire logic [5:0] integral_seconds,
  input wire logic action_downwards,
  input wire logic [2:0] preset_select,
  input wire logic [1:0] decimal_places,
  output logic [10:0] analog_output,
  output logic signed [15:0] scaled_reading,
  output logic [1:0] display_decimals,
  output logic regulating
);
  import pi_pkg::*;
  localparam int CW = $clog2(SAMPLE_CYCLES);

  if (SAMPLE_CYCLES < DIV_NW + 8) begin : g_chk
    $error("sample interval shorter than one calculation");
  end

  ////////////////////////////////////////////////////////////////////
  // settings: range limits and tuning selection
  logic [10:0] man_lim; // limited manual value
  logic signed [15:0] floor_eff, ceil_eff, sp_eff;
  logic signed [15:0] scale_eff, shift_eff;
  logic [6:0] min_eff;
  logic [5:0] sec_eff;
  logic [12:0] ti_sum;
  tuning_t tune_sel; // tuning that would be taken now

  always_comb begin
    // manual value 0..1000
    man_lim = (manual_output_value > 11'(OUT_MAX)) ? 11'(OUT_MAX)
            : manual_output_value; // RL10
    floor_eff = 16'(sat(49'(reading_floor), LIM_MIN, LIM_MAX)); // RL12
    ceil_eff = 16'(sat(49'(reading_ceiling), LIM_MIN, LIM_MAX)); // RL12
    sp_eff = 16'(sat(49'(target_setpoint), LIM_MIN, LIM_MAX)); // RL13
    scale_eff = 16'(sat(49'(scale_factor), -SCALE_MAX, SCALE_MAX));
    shift_eff = 16'(sat(49'(zero_shift), -SHIFT_MAX, SHIFT_MAX));
    // time as minutes and seconds, at least one second
    min_eff = (integral_minutes > 7'(MIN_MAX)) ? 7'(MIN_MAX) : integral_minutes;
    sec_eff = (integral_seconds > 6'(SEC_MAX)) ? 6'(SEC_MAX) : integral_seconds;
    ti_sum = 13'(min_eff * SEC_PER_MIN) + 13'(sec_eff); // RL15
    if (ti_sum == 13'h0000) ti_sum = 13'h0001; // RL15
    // user values or a preset as one set
    if (preset_select != 3'h0) begin
      tune_sel = preset_tuning(preset_select); // RL18
    end else begin
      tune_sel.gain = (proportional_gain > 14'(GAIN_MAX)) ? 14'(GAIN_MAX)
                    : proportional_gain; // RL14
      tune_sel.ti_s = ti_sum;
      tune_sel.dir_down = action_downwards;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // scaled reading, recomputed every cycle
  logic signed [15:0] scaled_r, scaled_nxt;
  logic signed [48:0] sc_prod; // reading times gain in hundredths
  logic signed [48:0] sc_raw;
  logic [1:0] dec_r, dec_nxt; // display only

  always_comb begin
    sc_prod = 49'(process_reading) * 49'(scale_eff);
    sc_raw = sc_prod / 49'(HUNDRED) + 49'(shift_eff); // RL4
    // ceiling first, floor wins if settings cross
    if (sc_raw > 49'(ceil_eff)) sc_raw = 49'(ceil_eff); // RL8
    if (sc_raw < 49'(floor_eff)) sc_raw = 49'(floor_eff); // RL8
    scaled_nxt = sc_raw[15:0];
    dec_nxt = decimal_places; // RL17
  end

  // registers only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      scaled_r <= 16'sh0000;
      dec_r <= 2'h0;
    end else begin
      scaled_r <= scaled_nxt;
      dec_r <= dec_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // loop error and the divider for the integral step
  logic signed [17:0] err, e_dir; // error and direction-adjusted error
  logic signed [48:0] gprod; // gain times error, fraction bits added
  logic [DIV_NW-1:0] div_num;
  logic [DIV_DW-1:0] div_den;
  logic [DIV_NW-1:0] div_quo;
  logic div_done;
  logic tick; // sample instant
  tuning_t tune_r, tune_nxt; // frozen during automatic run

  always_comb begin
    err = 18'(sp_eff) - 18'(scaled_r); // RL20
    e_dir = tune_r.dir_down ? -err : err; // RL23
    gprod = (49'(e_dir) * 49'(tune_r.gain)) <<< FRAC;
    div_num = gprod[48] ? DIV_NW'(-gprod) : DIV_NW'(gprod); // RL22
    div_den = DIV_DW'(tune_r.ti_s * TS_DEN); // RL22
  end

  divide_seq #(.NW(DIV_NW), .DW(DIV_DW)) u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(tick),
    .num(div_num),
    .den(div_den),
    .done(div_done),
    .quo(div_quo)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencing, integral sum and output
  ctrl_state_t state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt; // sample timer
  logic signed [31:0] acc_r, acc_nxt; // integral sum, FRAC bits
  logic signed [48:0] p_r, p_nxt; // proportional part
  logic signed [17:0] e_r, e_nxt; // sampled error
  logic neg_r, neg_nxt; // sign of integral step
  logic [10:0] out_r, out_nxt;
  logic regulating_r, regulating_nxt; // mode flag kept in a flop for the pin
  logic signed [48:0] inc, acc_sum, out_sum;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    tune_nxt = tune_r;
    acc_nxt = acc_r;
    p_nxt = p_r;
    e_nxt = e_r;
    neg_nxt = neg_r;
    out_nxt = out_r;
    tick = 1'b0;
    inc = neg_r ? -49'(div_quo) : 49'(div_quo);
    acc_sum = sat(49'(acc_r) + inc, 0, ACC_FULL); // RL24
    out_sum = sat((p_r + acc_sum) >>> FRAC, 0, OUT_MAX); // RL11
    if (hold_clear) begin
      // forced zero, mode input ignored
      out_nxt = 11'h000; // RL9
      state_nxt = ST_MANUAL; // RL9
      tune_nxt = tune_sel;
    end else if (!auto_manual_select) begin
      // manual: fixed value, tuning may change
      out_nxt = man_lim; // RL2
      state_nxt = ST_MANUAL; // RL1
      tune_nxt = tune_sel;
    end else begin
      unique case (state_r)
        ST_MANUAL: begin
          // bumpless start from the manual value
          acc_nxt = 32'(man_lim) <<< FRAC; // RL3
          cnt_nxt = '0;
          state_nxt = ST_WAIT; // RL1
        end
        ST_WAIT: begin
          if (cnt_r == CW'(SAMPLE_CYCLES - 1)) begin
            cnt_nxt = '0;
            tick = 1'b1; // RL19
            e_nxt = e_dir;
            neg_nxt = gprod[48];
            p_nxt = gprod / 49'(HUNDRED); // RL21
            state_nxt = ST_DIV;
          end else begin
            cnt_nxt = CW'(cnt_r + 1'b1);
          end
        end
        ST_DIV: begin
          // timer keeps running so the interval stays fixed
          cnt_nxt = CW'(cnt_r + 1'b1);
          if (div_done) state_nxt = ST_APPLY;
        end
        ST_APPLY: begin
          cnt_nxt = CW'(cnt_r + 1'b1);
          state_nxt = ST_WAIT;
          // zero error: leave output and sum alone
          if (e_r != 18'sh00000) begin // RL5
            acc_nxt = acc_sum[31:0]; // RL22
            out_nxt = out_sum[10:0]; // RL6 RL7 RL23
          end
        end
      endcase
    end
    // flag follows the state register it shadows
    regulating_nxt = (state_nxt != ST_MANUAL); // RL1
  end

  // registers only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_MANUAL;
      cnt_r <= '0;
      tune_r <= '{gain: 14'h0000, ti_s: 13'h0001, dir_down: 1'b0};
      acc_r <= 32'sh00000000;
      p_r <= '0;
      e_r <= 18'sh00000;
      neg_r <= 1'b0;
      out_r <= 11'h000;
      regulating_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      tune_r <= tune_nxt; // RL16
      acc_r <= acc_nxt;
      p_r <= p_nxt;
      e_r <= e_nxt;
      neg_r <= neg_nxt;
      out_r <= out_nxt;
      regulating_r <= regulating_nxt;
    end
  end

  assign analog_output = out_r;
  assign scaled_reading = scaled_r;
  assign display_decimals = dec_r;
  assign regulating = regulating_r;

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_hold;
    hold_clear |=> out_r == 11'h000;
  endproperty
  a_hold: assert property (p_hold) else $error("hold did not zero output"); // RL9

  property p_manual;
    !hold_clear && !auto_manual_select |=> out_r == $past(man_lim);
  endproperty
  a_manual: assert property (p_manual) else $error("manual value not output"); // RL2

  property p_range;
    out_r <= 11'(OUT_MAX);
  endproperty
  a_range: assert property (p_range) else $error("output out of range"); // RL11

  property p_entry;
    state_r == ST_MANUAL && auto_manual_select && !hold_clear
      |=> acc_r == (32'($past(man_lim)) <<< FRAC) && state_r == ST_WAIT;
  endproperty
  a_entry: assert property (p_entry) else $error("sum not loaded"); // RL3

  property p_clamp;
    ##1 scaled_r >= $past(floor_eff);
  endproperty
  a_clamp: assert property (p_clamp) else $error("reading below floor"); // RL8

  property p_frozen;
    state_r != ST_MANUAL && $past(state_r) != ST_MANUAL |-> tune_r == $past(tune_r);
  endproperty
  a_frozen: assert property (p_frozen) else $error("tuning changed"); // RL16

  property p_tick;
    tick |=> state_r == ST_DIV && cnt_r == '0;
  endproperty
  a_tick: assert property (p_tick) else $error("sample not taken"); // RL19

  property p_equal;
    state_r == ST_APPLY && e_r == 18'sh00000 && auto_manual_select && !hold_clear
      |=> $stable(out_r);
  endproperty
  a_equal: assert property (p_equal) else $error("output moved at zero error"); // RL5

  property p_div;
    tick ##1 (state_r == ST_DIV && auto_manual_select && !hold_clear)[*2]
      |-> ##[0:60] div_done;
  endproperty
  a_div: assert property (p_div) else $error("integral step late"); // RL22

  property p_wind;
    acc_r >= 0 && acc_r <= 32'(ACC_FULL);
  endproperty
  a_wind: assert property (p_wind) else $error("integral sum wound up"); // RL24

  c_start: cover property (state_r == ST_MANUAL ##1 state_r == ST_WAIT);
  c_apply: cover property (state_r == ST_APPLY && e_r != 18'sh00000);
  c_full: cover property (state_r == ST_APPLY ##1 out_r == 11'(OUT_MAX));
  c_hold: cover property (regulating && hold_clear);
endmodule

// ===== tb/process_plant.sv
// Purpose: far-side model, process sensor feeding the loop and actuator load
// Assumes: sensor updates on the falling clock edge like the rest of the stimulus
// Notes: with follow high the reading rises by half the actuator level
`timescale 1ns/1ns
module process_plant (
  input wire logic sys_clk,
  input wire logic follow,
  input wire logic signed [15:0] level,
  input wire logic [10:0] analog_output,
  output logic signed [15:0] process_reading
);
  ////////////////////////////////////////////////////////////////////////////
  // sensor value, open loop or coupled to the actuator
  initial process_reading = 16'sh0000;
  always @(negedge sys_clk) begin
    if (follow) begin
      // coupled plant: more drive gives a higher reading
      process_reading <= level + $signed({6'h00, analog_output[10:1]});
    end else begin
      // open loop: reading set by the bench
      process_reading <= level;
    end
  end
endmodule

// ===== tb/testbench.sv
// Purpose: self-checking bench for the pi loop controller
// Assumes: short sample period via SAMPLE_CYCLES, settings driven at falling edge
// Notes: first-sample output is predicted from the loop arithmetic
`timescale 1ns/1ns
module testbench;
  import pi_pkg::*;
  localparam int SC = 200; // shortened sample period
  logic sys_clk, rst, auto_manual_select, hold_clear, action_downwards, follow, regulating;
  logic signed [15:0] process_reading, scale_factor, zero_shift, reading_floor;
  logic signed [15:0] reading_ceiling, target_setpoint, level, scaled_reading;
  logic [10:0] manual_output_value, analog_output;
  logic [13:0] proportional_gain;
  logic [6:0] integral_minutes;
  logic [5:0] integral_seconds;
  logic [2:0] preset_select;
  logic [1:0] decimal_places, display_decimals;
  int fail_count, n_compared, s;
  int pg [6] = '{50, 100, 300, 120, 100, 70}; // preset gains, hundredths
  int pt [6] = '{30, 120, 5, 12, 1, 20}; // preset integral times, seconds
  ////////////////////////////////////////////////////////////////////////////
  // design and far side
  pi_loop_controller #(.SAMPLE_CYCLES(SC)) i_pi_loop_controller (.sys_clk(sys_clk),
    .rst(rst), .auto_manual_select(auto_manual_select), .hold_clear(hold_clear),
    .process_reading(process_reading), .scale_factor(scale_factor),
    .zero_shift(zero_shift), .reading_floor(reading_floor),
    .reading_ceiling(reading_ceiling), .target_setpoint(target_setpoint),
    .manual_output_value(manual_output_value), .proportional_gain(proportional_gain),
    .integral_minutes(integral_minutes), .integral_seconds(integral_seconds),
    .action_downwards(action_downwards), .preset_select(preset_select),
    .decimal_places(decimal_places), .analog_output(analog_output),
    .scaled_reading(scaled_reading), .display_decimals(display_decimals),
    .regulating(regulating));
  process_plant i_process_plant (.sys_clk(sys_clk), .follow(follow), .level(level),
    .analog_output(analog_output), .process_reading(process_reading));
  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // output after the first sample of automatic operation
  function automatic int exp_out(int g, int ti, bit dn, int e, int m);
    longint ep, p, st, sm, o;
    if (e == 0) return m;
    ep = dn ? -e : e;
    p = ep * g * 65536 / 100;
    st = ep * g * 65536 / (200 * ti);
    sm = longint'(m) * 65536 + st;
    if (sm < 0) sm = 0;
    if (sm > 1000 * 65536) sm = 1000 * 65536;
    o = (p + sm) >>> 16;
    if (o < 0) o = 0;
    if (o > 1000) o = 1000;
    return int'(o);
  endfunction
  // one manual-to-automatic transfer, checked at the first sample
  task automatic run(input logic [2:0] sel, input int g, mn, se, input logic dn, fl,
                     input int rd, scl, sh, ceil, sp, man, exp);
    int k;
    auto_manual_select = 1'b0;
    preset_select = sel;
    proportional_gain = 14'(g);
    integral_minutes = 7'(mn);
    integral_seconds = 6'(se);
    action_downwards = dn;
    level = 16'(rd);
    scale_factor = 16'(scl);
    zero_shift = 16'(sh);
    reading_ceiling = 16'(ceil);
    target_setpoint = 16'(sp);
    manual_output_value = 11'(man);
    tick(3);
    cmp_val({5'h00, analog_output}, 16'(man));
    auto_manual_select = 1'b1;
    tick(1);
    cmp_flag(regulating, 1'b1);
    // direction change while running must be ignored
    if (fl) action_downwards = ~dn;
    tick(SC - 10);
    cmp_val({5'h00, analog_output}, 16'(man));
    k = 0;
    while (exp != man && analog_output === 11'(man) && k < 100) begin
      tick(1);
      k++;
    end
    if (k == 100) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, analog_output, 11'(exp));
      conclude();
    end
    if (exp == man) tick(100);
    cmp_val({5'h00, analog_output}, 16'(exp));
    $display("test done: sel %0d gain %0d expect %0d", sel, g, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    fail_count = 0;
    n_compared = 0;
    rst = 1'b1;
    auto_manual_select = 1'b0;
    hold_clear = 1'b0;
    action_downwards = 1'b0;
    follow = 1'b0;
    level = 16'sh012c;
    scale_factor = 16'sh00c8;
    zero_shift = 16'sh0032;
    reading_floor = -16'sd10000;
    reading_ceiling = 16'sh4e20;
    target_setpoint = 16'sh01f4;
    manual_output_value = 11'h5dc;
    proportional_gain = 14'h0064;
    integral_minutes = 7'h00;
    integral_seconds = 6'h01;
    preset_select = 3'h0;
    decimal_places = 2'h3;
    tick(8);
    cmp_val({5'h00, analog_output}, 16'h0000);
    cmp_flag(regulating, 1'b0);
    rst = 1'b0;
    tick(3);
    cmp_val({5'h00, analog_output}, 16'h03e8);
    cmp_val(scaled_reading, 16'h028a);
    cmp_val({14'h0000, display_decimals}, 16'h0003);
    reading_ceiling = 16'sh0258;
    tick(2);
    cmp_val(scaled_reading, 16'h0258);
    reading_ceiling = 16'sh4e20;
    reading_floor = 16'sh02bc;
    tick(2);
    cmp_val(scaled_reading, 16'h02bc);
    reading_floor = 16'sh61a8;
    tick(2);
    cmp_val(scaled_reading, 16'h4e20);
    reading_floor = -16'sd10000;
    $display("test done: static settings");
    run(0, 100, 0, 1, 0, 0, 450, 100, 0, 20000, 500, 400,
        exp_out(100, 1, 0, 50, 400));
    hold_clear = 1'b1;
    tick(1);
    cmp_val({5'h00, analog_output}, 16'h0000);
    tick(5);
    cmp_flag(regulating, 1'b0);
    cmp_val({5'h00, analog_output}, 16'h0000);
    hold_clear = 1'b0;
    $display("test done: hold clear");
    run(0, 100, 0, 1, 0, 0, 550, 100, 0, 20000, 500, 400, exp_out(100, 1, 0, -50, 400));
    run(0, 100, 0, 1, 0, 0, 500, 100, 0, 20000, 500, 400, 400);
    run(0, 100, 0, 1, 1, 0, 450, 100, 0, 20000, 500, 400, exp_out(100, 1, 1, 50, 400));
    run(0, 100, 0, 1, 0, 1, 450, 100, 0, 20000, 500, 400, exp_out(100, 1, 0, 50, 400));
    run(0, 100, 0, 1, 0, 0, 275, 200, -100, 20000, 500, 400, exp_out(100, 1, 0, 50, 400));
    run(0, 100, 0, 1, 0, 0, 480, 100, 0, 450, 500, 400, exp_out(100, 1, 0, 50, 400));
    run(0, 9999, 0, 1, 0, 0, 450, 100, 0, 20000, 500, 400, 1000);
    run(0, 9999, 0, 1, 0, 0, 550, 100, 0, 20000, 500, 400, 0);
    run(0, 100, 1, 30, 0, 0, 450, 100, 0, 20000, 500, 400, exp_out(100, 90, 0, 50, 400));
    run(0, 250, 0, 1, 0, 0, 450, 100, 0, 20000, 500, 400, exp_out(250, 1, 0, 50, 400));
    // setpoint above range acts as 20000, so the error is 20000 - 450
    run(0, 1, 0, 1, 0, 0, 450, 100, 0, 20000, 30000, 400, exp_out(1, 1, 0, 19550, 400));
    for (s = 1; s <= 6; s++) begin
      run(3'(s), 0, 0, 9, 1, 0, 450, 100, 0, 20000, 500, 400,
          exp_out(pg[s-1], pt[s-1], 0, 50, 400));
    end
    follow = 1'b1;
    run(0, 100, 0, 1, 0, 0, 200, 100, 0, 20000, 500, 400, exp_out(100, 1, 0, 100, 400));
    conclude();
  end
endmodule
